// ---- design/handler_port_pkg.sv ----
package handler_port_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_KHZ = 40000;
    localparam int CNT_W = 24;
    localparam int TRIGGER_MIN_WIDTH_MS = 10;
    localparam int TRIGGER_TO_RUNNING_DELAY_MS = 20;
    localparam int RESULT_SETTLE_DELAY_MS = 5;
    localparam int STATUS_SETTLE_DELAY_MS = 5;
    localparam int INTER_STEP_GAP_SCREEN_ON_MS = 320;
    localparam int INTER_STEP_GAP_SCREEN_OFF_MS = 40;
    localparam int INTER_PROCEDURE_GAP_SCREEN_ON_MS = 280;
    localparam int INTER_PROCEDURE_GAP_SCREEN_OFF_MS = 60;
    localparam int SELECTOR_MIN_WIDTH_MS = 5;
    localparam int LOAD_STROBE_MIN_WIDTH_MS = 5;
    // least times: whole-ms figures times the rate are exact cycle counts
    localparam int TRIGGER_MIN_WIDTH_CYC = TRIGGER_MIN_WIDTH_MS * CLK_KHZ;
    localparam int TRIGGER_TO_RUNNING_DELAY_CYC = TRIGGER_TO_RUNNING_DELAY_MS * CLK_KHZ;
    localparam int RESULT_SETTLE_DELAY_CYC = RESULT_SETTLE_DELAY_MS * CLK_KHZ;
    localparam int STATUS_SETTLE_DELAY_CYC = STATUS_SETTLE_DELAY_MS * CLK_KHZ;
    localparam int STEP_GAP_ON_CYC = INTER_STEP_GAP_SCREEN_ON_MS * CLK_KHZ;
    localparam int STEP_GAP_OFF_CYC = INTER_STEP_GAP_SCREEN_OFF_MS * CLK_KHZ;
    localparam int PROC_GAP_ON_CYC = INTER_PROCEDURE_GAP_SCREEN_ON_MS * CLK_KHZ;
    localparam int PROC_GAP_OFF_CYC = INTER_PROCEDURE_GAP_SCREEN_OFF_MS * CLK_KHZ;
    localparam int SELECTOR_MIN_WIDTH_CYC = SELECTOR_MIN_WIDTH_MS * CLK_KHZ;
    localparam int LOAD_STROBE_MIN_WIDTH_CYC = LOAD_STROBE_MIN_WIDTH_MS * CLK_KHZ;

    // ==========================================================
    // port widths and filtered input indices
    // ==========================================================
    localparam int NUM_CH = 10;
    localparam int SEL_W = 3;
    localparam int NUM_IN = 6;
    localparam int IN_START = 0;
    localparam int IN_STOP = 1;
    localparam int IN_SEL0 = 2;
    localparam int IN_STROBE = 5;

    // ==========================================================
    // register map (byte addresses)
    // ==========================================================
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RESULT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_EVENT_CLR = 4'hc;
    // control fields
    localparam int CTRL_STEP_DONE = 0;
    localparam int CTRL_LAST_STEP = 1;
    localparam int CTRL_PAUSE = 2;
    localparam int CTRL_SCREEN_ON = 3;
    localparam int CTRL_ABORT = 4;
    // status fields
    localparam int STAT_RUNNING = 0;
    localparam int STAT_PAUSE = 1;
    localparam int STAT_GAP = 2;
    localparam int STAT_START_SEEN = 3;
    localparam int STAT_STOP_SEEN = 4;
    localparam int STAT_RECALL_SEEN = 5;
    localparam int STAT_SETUP_LSB = 8;
    // reset values
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [NUM_CH-1:0] RESULT_RESET = 10'h000;

    // ==========================================================
    // carriers and states
    // ==========================================================
    typedef struct packed {
        logic ext_start_n;
        logic ext_stop_n;
        logic setup_sel_bit2_n;
        logic setup_sel_bit1_n;
        logic setup_sel_bit0_n;
        logic setup_load_strobe_n;
    } handler_in_type;

    typedef struct packed {
        logic [NUM_CH-1:0] channel_result_out;
        logic pass_fail_out;
        logic test_running_out;
        logic sequence_done_out;
        logic pause_step_out;
    } handler_out_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_SETTLE,
        ST_STEP_GAP,
        ST_PROC_GAP
    } seq_state_type;

endpackage

// ---- design/test_handler_control_port.sv ----
// Operation
// - selector is three active-low lines, bit0 least significant, bit2 most
// - selector codes one to seven load stored setups one to seven
// - setup load happens only when the load strobe goes low
// - sequence done output high while a procedure runs, low otherwise
// - pause output asserted while the sequence sits in its pause step
// - running output rises within 20 ms of a valid start
// - pass/fail output settled at least 5 ms before handler reads it
// - running and done outputs change at least 5 ms after pass/fail settles
// - step gap about 320 ms screen on, 40 ms screen off
// - procedure gap about 280 ms screen on, 60 ms screen off
// - each channel output low on pass, high on fail
// - combined output low if all channels pass, high if any fails
// - running output high while a procedure executes, low otherwise
// - stop input acts on its low level, start input on its filtered falling edge
module test_handler_control_port
    import handler_port_pkg::*;
#(
    parameter logic [CNT_W-1:0] TRIG_MIN_CYC = CNT_W'(TRIGGER_MIN_WIDTH_CYC),
    parameter logic [CNT_W-1:0] SEL_MIN_CYC = CNT_W'(SELECTOR_MIN_WIDTH_CYC),
    // twin widths and screen-on gaps scale from the ones before them
    parameter logic [CNT_W-1:0] STROBE_MIN_CYC =
        CNT_W'(SEL_MIN_CYC * LOAD_STROBE_MIN_WIDTH_MS / SELECTOR_MIN_WIDTH_MS),
    parameter logic [CNT_W-1:0] RESULT_SETTLE_CYC = CNT_W'(RESULT_SETTLE_DELAY_CYC),
    parameter logic [CNT_W-1:0] STATUS_SETTLE_CYC =
        CNT_W'(RESULT_SETTLE_CYC * STATUS_SETTLE_DELAY_MS / RESULT_SETTLE_DELAY_MS),
    parameter logic [CNT_W-1:0] STEP_GAP_OFF = CNT_W'(STEP_GAP_OFF_CYC),
    parameter logic [CNT_W-1:0] STEP_GAP_ON =
        CNT_W'(STEP_GAP_OFF * INTER_STEP_GAP_SCREEN_ON_MS / INTER_STEP_GAP_SCREEN_OFF_MS),
    parameter logic [CNT_W-1:0] PROC_GAP_OFF = CNT_W'(PROC_GAP_OFF_CYC),
    parameter logic [CNT_W-1:0] PROC_GAP_ON =
        CNT_W'(PROC_GAP_OFF * INTER_PROCEDURE_GAP_SCREEN_ON_MS / INTER_PROCEDURE_GAP_SCREEN_OFF_MS)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // handler pins
    input wire handler_in_type handler_in,
    output handler_out_type handler_out,
    // setup recall toward the instrument
    output logic setup_load_pulse,
    output logic [SEL_W-1:0] setup_index
);

    // ==========================================================
    // helpers
    // ==========================================================
    function automatic logic [CNT_W-1:0] min_width(input int idx);
        if (idx == IN_START || idx == IN_STOP) begin
            return TRIG_MIN_CYC;
        end else if (idx == IN_STROBE) begin
            return STROBE_MIN_CYC;
        end
        return SEL_MIN_CYC;
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // input synchronisers and width filters
    // ==========================================================
    logic [NUM_IN-1:0] raw_in;
    logic [NUM_IN-1:0] sync1_ff;
    logic [NUM_IN-1:0] sync2_ff;
    logic [NUM_IN-1:0] filt_ff;
    logic [NUM_IN-1:0] filt_prev_ff;
    logic [CNT_W-1:0] flt_cnt_ff [NUM_IN];

    assign raw_in = {handler_in.setup_load_strobe_n, handler_in.setup_sel_bit2_n,
                     handler_in.setup_sel_bit1_n, handler_in.setup_sel_bit0_n,
                     handler_in.ext_stop_n, handler_in.ext_start_n};

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    // a level is accepted only after standing for its minimum width
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            filt_ff <= '1;
            filt_prev_ff <= '1;
            for (int i = 0; i < NUM_IN; i++) begin
                flt_cnt_ff[i] <= '0;
            end
        end else begin
            filt_prev_ff <= filt_ff;
            for (int i = 0; i < NUM_IN; i++) begin
                if (sync2_ff[i] == filt_ff[i]) begin
                    flt_cnt_ff[i] <= '0;
                end else if (flt_cnt_ff[i] + 1'b1 >= min_width(i)) begin
                    filt_ff[i] <= sync2_ff[i];
                    flt_cnt_ff[i] <= '0;
                end else begin
                    flt_cnt_ff[i] <= flt_cnt_ff[i] + 1'b1;
                end
            end
        end
    end

    logic start_evt;
    logic stop_lvl;
    logic strobe_evt;
    logic [SEL_W-1:0] sel_code;

    assign start_evt = filt_prev_ff[IN_START] & ~filt_ff[IN_START];
    assign stop_lvl = ~filt_ff[IN_STOP];
    assign strobe_evt = filt_prev_ff[IN_STROBE] & ~filt_ff[IN_STROBE];
    assign sel_code = ~filt_ff[IN_SEL0 +: SEL_W];

    // ==========================================================
    // avalon-mm slave: one wait cycle per access
    // ==========================================================
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic wr_en;
    logic [31:0] ctrl_ff;
    logic [NUM_CH-1:0] result_ff;
    logic [31:0] status_val;
    logic start_seen_ff;
    logic stop_seen_ff;
    logic recall_seen_ff;
    seq_state_type state_ff;

    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata = rdata_ff;
    assign wr_en = avs_write & ack_ff;

    always_comb begin
        status_val = '0;
        status_val[STAT_RUNNING] = handler_out.test_running_out;
        status_val[STAT_PAUSE] = handler_out.pause_step_out;
        status_val[STAT_GAP] = (state_ff == ST_STEP_GAP) | (state_ff == ST_PROC_GAP);
        status_val[STAT_START_SEEN] = start_seen_ff;
        status_val[STAT_STOP_SEEN] = stop_seen_ff;
        status_val[STAT_RECALL_SEEN] = recall_seen_ff;
        status_val[STAT_SETUP_LSB +: SEL_W] = setup_index;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ack_ff <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff <= (avs_read | avs_write) & ~ack_ff;
            if (avs_read & ~ack_ff) begin
                unique case (avs_address)
                    OFS_CTRL: rdata_ff <= ctrl_ff;
                    OFS_RESULT: rdata_ff <= 32'(result_ff);
                    OFS_STATUS: rdata_ff <= status_val;
                    default: rdata_ff <= '0;
                endcase
            end
        end
    end

    // control: pause and screen bits persist, step and abort bits act once
    logic step_req;
    logic abort_req;
    logic [31:0] ctrl_new;

    assign ctrl_new = be_merge(ctrl_ff, avs_writedata, avs_byteenable);
    assign step_req = wr_en & (avs_address == OFS_CTRL) & ctrl_new[CTRL_STEP_DONE];
    assign abort_req = wr_en & (avs_address == OFS_CTRL) & ctrl_new[CTRL_ABORT];

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= CTRL_RESET;
        end else if (wr_en && avs_address == OFS_CTRL) begin
            ctrl_ff <= ctrl_new & 32'h0000_000e;
        end else if (state_ff == ST_RUN && ctrl_ff[CTRL_PAUSE] && start_evt) begin
            ctrl_ff[CTRL_PAUSE] <= 1'b0; // start ends a waiting pause
        end else if (state_ff == ST_IDLE) begin
            ctrl_ff[CTRL_PAUSE] <= 1'b0;
        end
    end

    logic [31:0] result_new;

    assign result_new = be_merge(32'(result_ff), avs_writedata, avs_byteenable);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            result_ff <= RESULT_RESET;
        end else if (wr_en && avs_address == OFS_RESULT) begin
            result_ff <= result_new[NUM_CH-1:0];
        end
    end

    // sticky events, a new event beats a clear in the same cycle
    logic [31:0] clr_bits;
    logic recall_ok;

    assign clr_bits = (wr_en && avs_address == OFS_EVENT_CLR) ? (avs_writedata & {{8{avs_byteenable[3]}},
                      {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}}) : '0;
    assign recall_ok = strobe_evt & (sel_code != '0);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            start_seen_ff <= 1'b0;
            stop_seen_ff <= 1'b0;
            recall_seen_ff <= 1'b0;
        end else begin
            start_seen_ff <= start_evt | (start_seen_ff & ~clr_bits[STAT_START_SEEN]);
            stop_seen_ff <= (stop_lvl & filt_prev_ff[IN_STOP]) | (stop_seen_ff & ~clr_bits[STAT_STOP_SEEN]);
            recall_seen_ff <= recall_ok | (recall_seen_ff & ~clr_bits[STAT_RECALL_SEEN]);
        end
    end

    // ==========================================================
    // setup recall
    // ==========================================================
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            setup_load_pulse <= 1'b0;
            setup_index <= '0;
        end else begin
            setup_load_pulse <= recall_ok;
            if (recall_ok) begin
                setup_index <= sel_code;
            end
        end
    end

    // ==========================================================
    // test sequence
    // ==========================================================
    logic [CNT_W-1:0] timer_ff;
    logic last_ff;
    logic settle_done;
    logic [CNT_W-1:0] step_gap;
    logic [CNT_W-1:0] proc_gap;

    assign settle_done = (timer_ff + 1'b1 >= RESULT_SETTLE_CYC) && (timer_ff + 1'b1 >= STATUS_SETTLE_CYC);
    assign step_gap = ctrl_ff[CTRL_SCREEN_ON] ? STEP_GAP_ON : STEP_GAP_OFF;
    assign proc_gap = ctrl_ff[CTRL_SCREEN_ON] ? PROC_GAP_ON : PROC_GAP_OFF;

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            timer_ff <= '0;
            last_ff <= 1'b0;
        end else if ((stop_lvl || abort_req) && state_ff != ST_IDLE) begin
            state_ff <= ST_IDLE;
            timer_ff <= '0;
        end else begin
            timer_ff <= timer_ff + 1'b1;
            unique case (state_ff)
                ST_IDLE: begin
                    timer_ff <= '0;
                    if (start_evt && !stop_lvl) begin
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    timer_ff <= '0;
                    if (step_req) begin
                        last_ff <= ctrl_new[CTRL_LAST_STEP];
                        state_ff <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (settle_done) begin
                        timer_ff <= '0;
                        state_ff <= last_ff ? ST_PROC_GAP : ST_STEP_GAP;
                    end
                end
                ST_STEP_GAP: begin
                    if (timer_ff + 1'b1 >= step_gap) begin
                        timer_ff <= '0;
                        state_ff <= ST_RUN;
                    end
                end
                ST_PROC_GAP: begin
                    if (timer_ff + 1'b1 >= proc_gap) begin
                        timer_ff <= '0;
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // handler outputs
    // ==========================================================
    logic running;

    assign running = (state_ff == ST_RUN) || (state_ff == ST_SETTLE) || (state_ff == ST_STEP_GAP);

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            handler_out <= '0;
        end else begin
            handler_out.test_running_out <= running;
            handler_out.sequence_done_out <= running;
            handler_out.pause_step_out <= (state_ff == ST_RUN) & ctrl_ff[CTRL_PAUSE];
            if (state_ff == ST_RUN && step_req) begin
                handler_out.channel_result_out <= result_ff;
                handler_out.pass_fail_out <= |result_ff;
            end
        end
    end

endmodule // test_handler_control_port

// ---- testbench/handler_port_asserts.sv ----
module handler_port_asserts
    import handler_port_pkg::*;
#(
    parameter logic [CNT_W-1:0] STATUS_SETTLE_CYC = CNT_W'(STATUS_SETTLE_DELAY_CYC)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    // handler pins and recall
    input wire handler_in_type handler_in,
    input wire handler_out_type handler_out,
    input wire logic setup_load_pulse,
    input wire logic [SEL_W-1:0] setup_index
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // cycles since the result outputs last moved
    // ==========================================================
    logic [NUM_CH:0] prev_res_ff;
    logic [7:0] stable_cnt_ff;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev_res_ff <= '0;
            stable_cnt_ff <= 8'h00;
        end else begin
            prev_res_ff <= {handler_out.channel_result_out, handler_out.pass_fail_out};
            if (prev_res_ff != {handler_out.channel_result_out, handler_out.pass_fail_out}) begin
                stable_cnt_ff <= 8'h00;
            end else if (stable_cnt_ff != 8'hff) begin
                stable_cnt_ff <= stable_cnt_ff + 8'h01;
            end
        end
    end

    // ==========================================================
    // properties
    // ==========================================================
    sequence start_held_s;
        $fell(handler_in.ext_start_n) && !handler_out.test_running_out && handler_in.ext_stop_n
            ##1 !handler_in.ext_start_n [*8];
    endsequence

    done_tracks_run_a: assert property (handler_out.sequence_done_out == handler_out.test_running_out)
        else $error("done output differs from running output");
    pass_fail_any_a: assert property (handler_out.pass_fail_out == |handler_out.channel_result_out)
        else $error("combined result not the or of channel results");
    start_to_run_a: assert property (start_held_s |-> ##[1:8] handler_out.test_running_out)
        else $error("running output late after start");
    run_needs_start_a: assert property ($rose(handler_out.test_running_out) |->
        !$past(handler_in.ext_start_n, 3) && !$past(handler_in.ext_start_n, 8))
        else $error("running rose without a held start");
    load_needs_strobe_a: assert property (setup_load_pulse |->
        !$past(handler_in.setup_load_strobe_n, 3) && !$past(handler_in.setup_load_strobe_n, 5))
        else $error("setup load without a held strobe");
    load_code_map_a: assert property (setup_load_pulse |-> setup_index != 3'h0 && setup_index ==
        ~{handler_in.setup_sel_bit2_n, handler_in.setup_sel_bit1_n, handler_in.setup_sel_bit0_n})
        else $error("setup index does not match selector code");
    index_on_load_a: assert property ($changed(setup_index) |-> setup_load_pulse)
        else $error("setup index moved without a load");
    settle_order_a: assert property ($fell(handler_out.test_running_out) |->
        stable_cnt_ff >= 8'(STATUS_SETTLE_CYC - 2))
        else $error("running fell before results settled");
    channel_hold_a: assert property ($changed(handler_out.channel_result_out) |->
        handler_out.test_running_out)
        else $error("channel results moved outside a procedure");
    bus_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
endmodule // handler_port_asserts

bind test_handler_control_port handler_port_asserts #(.STATUS_SETTLE_CYC(STATUS_SETTLE_CYC)) i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .handler_in(handler_in), .handler_out(handler_out),
    .setup_load_pulse(setup_load_pulse), .setup_index(setup_index));

// ---- testbench/handler_model.sv ----
module handler_model
    import handler_port_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // pins toward the port
    output handler_in_type handler_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        handler_in = '1;
    end

    // ==========================================================
    // start or stop held low, stop acts on the low level, start on its falling edge
    // ==========================================================
    task automatic hold_low(input bit stop, input int cyc);
        @(posedge sys_clk);
        if (stop) handler_in.ext_stop_n <= 1'b0;
        else handler_in.ext_start_n <= 1'b0;
        repeat (cyc) @(posedge sys_clk);
        handler_in.ext_start_n <= 1'b1;
        handler_in.ext_stop_n <= 1'b1;
    endtask

    // ==========================================================
    // recall: inverted code, bit0 lsb, selectors framing the strobe
    // ==========================================================
    task automatic recall(input logic [2:0] code, input int cyc);
        @(posedge sys_clk);
        {handler_in.setup_sel_bit2_n, handler_in.setup_sel_bit1_n, handler_in.setup_sel_bit0_n} <= ~code;
        repeat (8) @(posedge sys_clk);
        handler_in.setup_load_strobe_n <= 1'b0;
        repeat (cyc) @(posedge sys_clk);
        handler_in.setup_load_strobe_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        {handler_in.setup_sel_bit2_n, handler_in.setup_sel_bit1_n, handler_in.setup_sel_bit0_n} <= 3'h7;
    endtask
endmodule // handler_model

// ---- testbench/test_handler_control_port_tb.sv ----
module test_handler_control_port_tb
    import handler_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    handler_in_type handler_in;
    handler_out_type handler_out;
    logic setup_load_pulse;
    logic [SEL_W-1:0] setup_index;
    logic [SEL_W-1:0] last_idx = '0;
    logic [31:0] q;
    int error_cnt = 0;
    int samples_checked = 0;
    int pulse_cnt = 0;
    int cyc = 0;
    int n0;

    test_handler_control_port #(.TRIG_MIN_CYC(24'h8), .SEL_MIN_CYC(24'h4), .RESULT_SETTLE_CYC(24'h6),
        .STEP_GAP_OFF(24'ha), .PROC_GAP_OFF(24'hc)) i_dut (
        .sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .handler_in(handler_in),
        .handler_out(handler_out), .setup_load_pulse(setup_load_pulse), .setup_index(setup_index));
    handler_model i_handler (.sys_clk(sys_clk), .handler_in(handler_in));

    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ==========================================================
    // monitor, timeout and closing
    // ==========================================================
    always @(posedge sys_clk) begin
        cyc++;
        if (setup_load_pulse === 1'b1) begin
            pulse_cnt++;
            last_idx = setup_index;
        end
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        avs_byteenable <= 4'hf;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic pause_cyc(input int c);
        repeat (c) @(negedge sys_clk);
    endtask

    task automatic wait_run(input logic v);
        int n;
        n = 0;
        while (handler_out.test_running_out !== v && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        chk(32'(handler_out.test_running_out), 32'(v));
    endtask

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        pause_cyc(1);
        chk(32'(handler_out), 32'h0000_0000);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(q, CTRL_RESET);
        bus(1'b0, OFS_RESULT, 32'h0);
        chk(q, 32'(RESULT_RESET));
        bus(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0000_0000);
        i_handler.hold_low(1'b0, 4);
        pause_cyc(20);
        chk(32'(handler_out.test_running_out), 32'h0);
        i_handler.hold_low(1'b0, 12);
        wait_run(1'b1);
        chk(32'(handler_out.sequence_done_out), 32'h1);
        bus(1'b1, OFS_RESULT, 32'h0000_0005);
        bus(1'b1, OFS_CTRL, 32'h0000_0001);
        pause_cyc(4);
        chk(32'(handler_out.channel_result_out), 32'h0000_0005);
        chk(32'(handler_out.pass_fail_out), 32'h1);
        pause_cyc(30);
        chk(32'(handler_out.test_running_out), 32'h1);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk((q >> STAT_GAP) & 32'h1, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h0000_0004);
        pause_cyc(3);
        chk(32'(handler_out.pause_step_out), 32'h1);
        i_handler.hold_low(1'b0, 12);
        pause_cyc(6);
        chk(32'(handler_out.pause_step_out), 32'h0);
        bus(1'b1, OFS_RESULT, 32'h0);
        bus(1'b1, OFS_CTRL, 32'h0000_000b);
        wait_run(1'b0);
        chk(32'(handler_out), 32'h0000_0000);
        pause_cyc(30);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk((q >> STAT_GAP) & 32'h1, 32'h1);
        for (int c = 0; c < 8; c++) begin
            n0 = pulse_cnt;
            i_handler.recall(3'(c), 10);
            pause_cyc(4);
            chk(32'(pulse_cnt - n0), (c == 0) ? 32'h0 : 32'h1);
            if (c != 0) chk(32'(last_idx), 32'(c));
        end
        n0 = pulse_cnt;
        i_handler.recall(3'h3, 2);
        pause_cyc(4);
        chk(32'(pulse_cnt - n0), 32'h0);
        bus(1'b1, OFS_STATUS, 32'h0000_0000);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk((q >> STAT_SETUP_LSB) & 32'h7, 32'h7);
        chk((q >> STAT_START_SEEN) & 32'h7, 32'h5);
        i_handler.hold_low(1'b0, 12);
        wait_run(1'b1);
        bus(1'b1, OFS_CTRL, 32'h0000_0010);
        wait_run(1'b0);
        pause_cyc(20);
        i_handler.hold_low(1'b0, 12);
        wait_run(1'b1);
        i_handler.hold_low(1'b1, 12);
        wait_run(1'b0);
        bus(1'b1, OFS_EVENT_CLR, 32'h0000_0038);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk((q >> STAT_START_SEEN) & 32'h7, 32'h0);
        test_done();
    end
endmodule // test_handler_control_port_tb
